// file: core/dma_hold_sequencer.sv
// Purpose: hold sequencer and priority chain toward the host bus
// Assumes: hostClk rises on each trailing edge of host phase 2
// Notes: open-drain hold line is split into in, constant low out, enable
// Function
// - Upper-half access stalls CPU, requests hold
// - Host command write latches byte, sets flag
// - Local read of command byte clears flag
// - Third stage raises wait, write strobe
// - Fourth stage passes host ready to CPU
// - Transfer ends when both strobes high
// - No pending byte: clear, release hold
// - Pending byte: keep hold, back to load
// - Retained hold: first two stages high
// - Retain until flag clears or new transfer
// - Held host needs no new acknowledge
// - Unconnected priority input reads inactive
// - Priority out low if in low or busy
// - Start only with priority and hold high
// - Start by pulling hold low on edge
// - Priority out low on same edge
// - Priority lost next edge aborts transfer
// - Chain decides only same-edge starts
`timescale 1ns/1ps
module dma_hold_sequencer
  import dma_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hostClk,
  input wire logic [ADDR_W-1:0] localAddr,
  input wire logic localMemRead_n,
  input wire logic localMemWrite_n,
  input wire logic [DATA_W-1:0] localWriteData,
  output logic localCpuReady,
  output logic [DATA_W-1:0] localReadData,
  input wire logic hostHoldAck,
  input wire logic hostReadyIn,
  input wire logic hostCmdWrite,
  input wire logic [DATA_W-1:0] hostCmdData,
  input wire logic sharedHoldIn_n,
  output logic sharedHoldOut_n,
  output logic sharedHoldOe,
  input wire logic chainPriorityIn_n,
  input wire logic chainPriorityInDriven,
  output logic chainPriorityOut_n,
  output logic hostWaitIndicate,
  output logic hostWriteStrobe_n,
  output logic hostBusDriveEn,
  output logic [HOST_ADDR_W-1:0] hostAddr,
  input wire logic [DATA_W-1:0] hostDataIn,
  output logic [DATA_W-1:0] hostDataOut,
  output logic hostDataOe,
  output logic commandPending_n
);
  seq_link_if link ();

  logic mrs1_reg;
  logic mrs2_reg;
  logic hrs1_reg;
  logic hrs2_reg;
  logic hostRst_n;
  logic dreq1_reg;
  logic dreq2_reg;
  logic ctog1_reg;
  logic ctog2_reg;
  logic ctog3_reg;
  logic clrPulse;
  logic cmdPending_reg;
  logic [DATA_W-1:0] cmdByte_reg;
  logic chain_priority_in_n;
  logic holdLineHigh;
  logic request;
  logic [3:0] stage;
  seq_state_e state_reg;
  seq_state_e state_next;
  logic dmaWrite_reg;
  logic [HOST_ADDR_W-1:0] hostAddr_reg;
  logic [DATA_W-1:0] hostDataOut_reg;
  logic [DATA_W-1:0] hostRdata_reg;
  logic readyPass_reg;

  // Local reset release, two flops on mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mrs1_reg <= 1'b0;
      mrs2_reg <= 1'b0;
    end else begin
      mrs1_reg <= 1'b1;
      mrs2_reg <= mrs1_reg;
    end
  end

  // Host-side reset release, two flops on hostClk
  always_ff @(posedge hostClk or negedge arst_n) begin
    if (!arst_n) begin
      hrs1_reg <= 1'b0;
      hrs2_reg <= 1'b0;
    end else begin
      hrs1_reg <= 1'b1;
      hrs2_reg <= hrs1_reg;
    end
  end

  assign hostRst_n = hrs2_reg;

  local_cpu_port localPort (
    .mclk(mclk),
    .rst_n(mrs2_reg),
    .localAddr(localAddr),
    .localMemRead_n(localMemRead_n),
    .localMemWrite_n(localMemWrite_n),
    .localWriteData(localWriteData),
    .localCpuReady(localCpuReady),
    .localReadData(localReadData),
    .link(link.local_side)
  );

  // Request level and clear toggle brought into hostClk
  always_ff @(posedge hostClk or negedge hostRst_n) begin
    if (!hostRst_n) begin
      dreq1_reg <= 1'b0;
      dreq2_reg <= 1'b0;
      ctog1_reg <= 1'b0;
      ctog2_reg <= 1'b0;
      ctog3_reg <= 1'b0;
    end else begin
      dreq1_reg <= link.dmaReq;
      dreq2_reg <= dreq1_reg;
      ctog1_reg <= link.cmdClrToggle;
      ctog2_reg <= ctog1_reg;
      ctog3_reg <= ctog2_reg;
    end
  end

  assign clrPulse = ctog2_reg ^ ctog3_reg;

  // Command flag; a host write in the clearing cycle keeps it set
  always_ff @(posedge hostClk or negedge hostRst_n) begin
    if (!hostRst_n) begin
      cmdPending_reg <= 1'b0;
      cmdByte_reg <= DATA_RESET;
    end else if (hostCmdWrite) begin
      cmdPending_reg <= 1'b1;
      cmdByte_reg <= hostCmdData;
    end else if (clrPulse) begin
      cmdPending_reg <= 1'b0;
    end
  end

  // Open priority input reads as the inactive high level
  assign chain_priority_in_n = chainPriorityInDriven ? chainPriorityIn_n : 1'b1;
  assign holdLineHigh = sharedHoldIn_n;
  // Either a local transfer or a pending byte wants the host held
  assign request = dreq2_reg | cmdPending_reg;

  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SEQ_IDLE: begin
        // Wait for priority and a free hold line
        if (request && chain_priority_in_n && holdLineHigh) begin
          state_next = SEQ_ARB;
        end
      end
      SEQ_ARB: begin
        // Priority is checked once more on the next edge
        if (!chain_priority_in_n) begin
          state_next = SEQ_IDLE;
        end else if (hostHoldAck) begin
          state_next = SEQ_HELD;
        end else begin
          state_next = SEQ_ACK;
        end
      end
      SEQ_ACK: begin
        if (hostHoldAck) begin
          state_next = SEQ_HELD;
        end else if (!request) begin
          state_next = SEQ_IDLE;
        end
      end
      SEQ_HELD: begin
        // Held host: a new transfer shifts on at once
        if (dreq2_reg) begin
          state_next = SEQ_WAIT;
        end else if (!cmdPending_reg) begin
          state_next = SEQ_IDLE;
        end
      end
      SEQ_WAIT: begin
        state_next = SEQ_READY;
      end
      SEQ_READY: begin
        // End of transfer: retain the hold only for a pending byte
        if (!dreq2_reg) begin
          state_next = cmdPending_reg ? SEQ_HELD : SEQ_IDLE;
        end
      end
      default: begin
        state_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge hostClk or negedge hostRst_n) begin
    if (!hostRst_n) begin
      state_reg <= SEQ_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stage image of the shift register
  always_comb begin
    unique case (state_reg)
      SEQ_IDLE: stage = STG_NONE;
      SEQ_ARB: stage = STG_FIRST;
      SEQ_ACK: stage = STG_FIRST;
      SEQ_HELD: stage = STG_HELD;
      SEQ_WAIT: stage = STG_WAIT;
      SEQ_READY: stage = STG_READY;
      default: stage = STG_NONE;
    endcase
  end

  // Transfer data captured as the third stage rises
  always_ff @(posedge hostClk or negedge hostRst_n) begin
    if (!hostRst_n) begin
      dmaWrite_reg <= 1'b0;
      hostAddr_reg <= HADDR_RESET;
      hostDataOut_reg <= DATA_RESET;
    end else if (state_next == SEQ_WAIT && state_reg != SEQ_WAIT) begin
      dmaWrite_reg <= link.dmaWrite;
      hostAddr_reg <= link.dmaAddr;
      hostDataOut_reg <= link.dmaWdata;
    end
  end

  // Ready is registered before it crosses to avoid glitches
  always_ff @(posedge hostClk or negedge hostRst_n) begin
    if (!hostRst_n) begin
      readyPass_reg <= 1'b0;
      hostRdata_reg <= DATA_RESET;
    end else begin
      readyPass_reg <= (state_reg == SEQ_READY) & hostReadyIn;
      if (state_reg == SEQ_READY && hostReadyIn && !dmaWrite_reg) begin
        hostRdata_reg <= hostDataIn;
      end
    end
  end

  // Hold line: first stage pulls it low
  assign sharedHoldOut_n = 1'b0;
  assign sharedHoldOe = stage[0];
  // Busy or blocked upstream pulls the chain low
  assign chainPriorityOut_n = chain_priority_in_n & (state_reg == SEQ_IDLE);
  assign hostBusDriveEn = stage[1];
  // Both drop as soon as the third stage clears
  assign hostWaitIndicate = stage[2];
  assign hostWriteStrobe_n = ~(stage[2] & dmaWrite_reg);
  assign hostDataOe = stage[2] & dmaWrite_reg;
  assign hostAddr = hostAddr_reg;
  assign hostDataOut = hostDataOut_reg;
  assign commandPending_n = ~cmdPending_reg;

  assign link.readyPass = readyPass_reg;
  assign link.hostRdata = hostRdata_reg;
  assign link.cmdPending = cmdPending_reg;
  assign link.cmdByte = cmdByte_reg;

  a_start_needs_grant: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    $rose(sharedHoldOe) |-> $past(chain_priority_in_n) && $past(holdLineHigh))
    else $error("hold asserted without priority or free line");

  a_hold_with_chain_priority_out_n: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    sharedHoldOe |-> !chainPriorityOut_n)
    else $error("priority out high while hold driven");

  a_chain_priority_out_n_follows_in: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    !chain_priority_in_n |-> !chainPriorityOut_n)
    else $error("priority out not passed down the chain");

  a_abort_on_loss: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_ARB && !chain_priority_in_n) |=> !sharedHoldOe && !hostBusDriveEn)
    else $error("transfer not aborted after priority loss");

  a_wait_after_held: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_HELD && dreq2_reg) |=> hostWaitIndicate ##1 stage[3])
    else $error("third or fourth stage late");

  a_no_ack_retained: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_HELD && dreq2_reg) |=> state_reg == SEQ_WAIT)
    else $error("retained hold waited for acknowledge");

  a_end_release: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_READY && !dreq2_reg && !cmdPending_reg)
      |=> !sharedHoldOe && !hostWaitIndicate && hostWriteStrobe_n)
    else $error("hold or strobes not released at end");

  a_end_retain: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_READY && !dreq2_reg && cmdPending_reg)
      |=> stage == STG_HELD && !hostWaitIndicate)
    else $error("hold not retained for pending byte");

  a_cmd_sets_flag: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    hostCmdWrite |=> !commandPending_n && cmdByte_reg == $past(hostCmdData))
    else $error("command byte not latched");

  a_ready_passes: assert property (@(posedge hostClk) disable iff (!hostRst_n)
    (state_reg == SEQ_READY) |=> readyPass_reg == $past(hostReadyIn))
    else $error("host ready not passed in fourth stage");
endmodule

// file: core/dma_seq_pkg.sv
// Purpose: shared constants for the DMA hold sequencer
// Assumes: 16-bit local address, 8-bit data, 15-bit host window
// Notes: stage vectors are {fourth, third, second, first}
package dma_seq_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int HOST_ADDR_W = 15;
  // Upper half of the local space maps onto the host bus
  localparam int UPPER_BIT = 15;
  localparam logic [ADDR_W-1:0] CMD_DATA_ADDR = 16'h1400;
  localparam logic [ADDR_W-1:0] CMD_STATUS_ADDR = 16'h1800;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [HOST_ADDR_W-1:0] HADDR_RESET = 15'h0000;
  localparam logic [6:0] STATUS_PAD = 7'h00;

  // Sequencer stage images
  localparam logic [3:0] STG_NONE = 4'h0;
  localparam logic [3:0] STG_FIRST = 4'h1;
  localparam logic [3:0] STG_HELD = 4'h3;
  localparam logic [3:0] STG_WAIT = 4'h7;
  localparam logic [3:0] STG_READY = 4'hF;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_ARB = 3'b001,
    SEQ_ACK = 3'b010,
    SEQ_HELD = 3'b011,
    SEQ_WAIT = 3'b100,
    SEQ_READY = 3'b101
  } seq_state_e;
endpackage

// file: core/seq_link_if.sv
// Purpose: carries the local-side request and the host-side answers
// Assumes: request fields are stable while dmaReq is high
// Notes: readyPass, cmdPending and cmdByte cross into mclk at the receiver
`timescale 1ns/1ps
interface seq_link_if;
  logic dmaReq;
  logic dmaWrite;
  logic [14:0] dmaAddr;
  logic [7:0] dmaWdata;
  logic cmdClrToggle;
  logic readyPass;
  logic [7:0] hostRdata;
  logic cmdPending;
  logic [7:0] cmdByte;
  modport local_side (
    output dmaReq, dmaWrite, dmaAddr, dmaWdata, cmdClrToggle,
    input readyPass, hostRdata, cmdPending, cmdByte
  );
  modport host_side (
    input dmaReq, dmaWrite, dmaAddr, dmaWdata, cmdClrToggle,
    output readyPass, hostRdata, cmdPending, cmdByte
  );
endinterface

// file: core/local_cpu_port.sv
// Purpose: local processor side of the DMA window and command port
// Assumes: local processor runs on mclk; strobes are synchronous to it
// Notes: host-domain levels pass two flip-flops before use
`timescale 1ns/1ps
module local_cpu_port
  import dma_seq_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] localAddr,
  input wire logic localMemRead_n,
  input wire logic localMemWrite_n,
  input wire logic [DATA_W-1:0] localWriteData,
  output logic localCpuReady,
  output logic [DATA_W-1:0] localReadData,
  seq_link_if.local_side link
);
  logic dmaCycle;
  logic cmdRead;
  logic statRead;
  logic dmaReq_reg;
  logic dmaWrite_reg;
  logic [HOST_ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic rdySync1_reg;
  logic rdySync2_reg;
  logic pndSync1_reg;
  logic pndSync2_reg;
  logic seenLow_reg;
  logic cmdReadPrev_reg;
  logic clrToggle_reg;
  logic [DATA_W-1:0] rdata_reg;

  // Upper half access with either strobe low opens a transfer
  assign dmaCycle = localAddr[UPPER_BIT] & (~localMemRead_n | ~localMemWrite_n);
  assign cmdRead = (localAddr == CMD_DATA_ADDR) & ~localMemRead_n;
  assign statRead = (localAddr == CMD_STATUS_ADDR) & ~localMemRead_n;

  // Request held until both strobes return high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dmaReq_reg <= 1'b0;
      dmaWrite_reg <= 1'b0;
      addr_reg <= HADDR_RESET;
      wdata_reg <= DATA_RESET;
    end else begin
      dmaReq_reg <= dmaCycle;
      if (dmaCycle && !dmaReq_reg) begin
        dmaWrite_reg <= ~localMemWrite_n;
        addr_reg <= localAddr[HOST_ADDR_W-1:0];
        wdata_reg <= localWriteData;
      end
    end
  end

  // Host-domain levels, two flops each
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdySync1_reg <= 1'b0;
      rdySync2_reg <= 1'b0;
      pndSync1_reg <= 1'b0;
      pndSync2_reg <= 1'b0;
    end else begin
      rdySync1_reg <= link.readyPass;
      rdySync2_reg <= rdySync1_reg;
      pndSync1_reg <= link.cmdPending;
      pndSync2_reg <= pndSync1_reg;
    end
  end

  // A stale ready from the last transfer must not release the next one
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seenLow_reg <= 1'b0;
    end else if (!dmaReq_reg) begin
      seenLow_reg <= 1'b0;
    end else if (!rdySync2_reg) begin
      seenLow_reg <= 1'b1;
    end
  end

  // Stall during a transfer until host ready is passed through
  assign localCpuReady = ~dmaCycle | (dmaReq_reg & seenLow_reg & rdySync2_reg);

  // Reading the command byte asks the host side to drop the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReadPrev_reg <= 1'b0;
      clrToggle_reg <= 1'b0;
    end else begin
      cmdReadPrev_reg <= cmdRead;
      if (cmdRead && !cmdReadPrev_reg) begin
        clrToggle_reg <= ~clrToggle_reg;
      end
    end
  end

  // Read data: command byte, status bit or host read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= DATA_RESET;
    end else if (cmdRead) begin
      rdata_reg <= link.cmdByte;
    end else if (statRead) begin
      rdata_reg <= {STATUS_PAD, pndSync2_reg};
    end else if (dmaReq_reg && seenLow_reg && rdySync2_reg) begin
      rdata_reg <= link.hostRdata;
    end
  end

  assign localReadData = rdata_reg;
  assign link.dmaReq = dmaReq_reg;
  assign link.dmaWrite = dmaWrite_reg;
  assign link.dmaAddr = addr_reg;
  assign link.dmaWdata = wdata_reg;
  assign link.cmdClrToggle = clrToggle_reg;

  a_stall_on_open: assert property (@(posedge mclk) disable iff (!rst_n)
    (dmaCycle && !dmaReq_reg) |-> !localCpuReady)
    else $error("transfer start did not stall the local processor");
endmodule

// file: tb/host_bus_model.sv
// Purpose: host bus model granting hold and answering DMA cycles
// Assumes: hostClk runs free; the hold line is resolved by the bench
// Notes: read data is valid only while the device reads, inverted otherwise
`timescale 1ns/1ps
module host_bus_model (
  input wire logic hostClk,
  input wire logic holdLine_n,
  input wire logic hostWaitIndicate,
  input wire logic hostWriteStrobe_n,
  input wire logic [14:0] hostAddr,
  input wire logic [7:0] hostDataOut,
  input wire logic [3:0] ackDelay,
  input wire logic [3:0] rdyDelay,
  output logic hostHoldAck,
  output logic hostReadyIn,
  output logic [7:0] hostDataIn,
  output logic [14:0] wrAddr,
  output logic [7:0] wrData
);
  logic [3:0] holdCnt = 4'h0;
  logic [3:0] waitCnt = 4'h0;
  logic [7:0] rd;
  // Ack only after the line stayed low ackDelay edges; drops with the line
  always @(posedge hostClk) begin
    holdCnt <= holdLine_n ? 4'h0 : holdCnt + {3'h0, holdCnt != 4'hF};
    hostHoldAck <= !holdLine_n && (holdCnt >= ackDelay);
  end
  // Ready stretched by rdyDelay edges so slow memory is exercised
  always @(posedge hostClk) begin
    waitCnt <= hostWaitIndicate ? waitCnt + {3'h0, waitCnt != 4'hF} : 4'h0;
    hostReadyIn <= hostWaitIndicate && (waitCnt >= rdyDelay);
    if (!hostWriteStrobe_n) begin
      wrAddr <= hostAddr;
      wrData <= hostDataOut;
    end
  end
  // Undriven bus shows the inverse so stale values never pass
  assign rd = hostAddr[7:0] ^ 8'hA5;
  assign hostDataIn = (hostWaitIndicate && hostWriteStrobe_n) ? rd : ~rd;
endmodule

// file: tb/dma_hold_sequencer_priority_chain_test.sv
// Purpose: self-checking bench for the DMA hold sequencer
// Assumes: host model answers holds; a second controller is a bench level
// Notes: host-side samples are taken 1 ns after a hostClk edge, except the cpu_finish checks, taken at a negedge of mclk
`timescale 1ns/1ps
module dma_hold_sequencer_priority_chain_test;
  logic mclk = 1'b0;
  logic hostClk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] localAddr = 16'h0000;
  logic localMemRead_n = 1'b1;
  logic localMemWrite_n = 1'b1;
  logic [7:0] localWriteData = 8'h00;
  logic hostCmdWrite = 1'b0;
  logic [7:0] hostCmdData = 8'h00;
  logic chainPriorityIn_n = 1'b0;
  logic chainPriorityInDriven = 1'b0;
  logic otherHold_n = 1'b1;
  logic [3:0] ackDelay = 4'h1;
  logic [3:0] rdyDelay = 4'h0;
  logic localCpuReady, holdOut_n, holdOe, prioOut_n, hostWait, hostWr_n, driveEn, dataOe, cmdPend_n;
  logic hostHoldAck, hostReadyIn, holdLine_n;
  logic [7:0] localReadData, hostDataIn, hostDataOut, wrData, q;
  logic [14:0] hostAddr, wrAddr;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  // Local clock 5 ns, link clock 12 ns, edges coincide every 30 ns
  always #2.5 mclk = ~mclk;
  always #6 hostClk = ~hostClk;
  // Open-drain hold line: this device, the other controller, pull-up
  assign holdLine_n = (holdOe ? holdOut_n : 1'b1) & otherHold_n;
  dma_hold_sequencer DUT (.mclk(mclk), .arst_n(arst_n), .hostClk(hostClk), .localAddr(localAddr),
    .localMemRead_n(localMemRead_n), .localMemWrite_n(localMemWrite_n), .localWriteData(localWriteData),
    .localCpuReady(localCpuReady), .localReadData(localReadData), .hostHoldAck(hostHoldAck),
    .hostReadyIn(hostReadyIn), .hostCmdWrite(hostCmdWrite), .hostCmdData(hostCmdData),
    .sharedHoldIn_n(holdLine_n), .sharedHoldOut_n(holdOut_n), .sharedHoldOe(holdOe),
    .chainPriorityIn_n(chainPriorityIn_n), .chainPriorityInDriven(chainPriorityInDriven),
    .chainPriorityOut_n(prioOut_n), .hostWaitIndicate(hostWait), .hostWriteStrobe_n(hostWr_n),
    .hostBusDriveEn(driveEn), .hostAddr(hostAddr), .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOe(dataOe), .commandPending_n(cmdPend_n));
  host_bus_model host (.hostClk(hostClk), .holdLine_n(holdLine_n), .hostWaitIndicate(hostWait),
    .hostWriteStrobe_n(hostWr_n), .hostAddr(hostAddr), .hostDataOut(hostDataOut), .ackDelay(ackDelay),
    .rdyDelay(rdyDelay), .hostHoldAck(hostHoldAck), .hostReadyIn(hostReadyIn), .hostDataIn(hostDataIn),
    .wrAddr(wrAddr), .wrData(wrData));
  task automatic cmp_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic h_wait(input int n);
    repeat (n) @(posedge hostClk);
    #1;
  endtask
  // Bounded wait for the hold enable, then judged
  task automatic wait_oe(input logic v);
    int n;
    n = 0;
    h_wait(1);
    while (holdOe !== v && n < 60) begin
      h_wait(1);
      n++;
    end
    cmp_bit(holdOe, v);
  endtask
  task automatic cpu_start(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(posedge mclk);
    #1;
    localAddr = a;
    localWriteData = d;
    localMemWrite_n = !wr;
    localMemRead_n = wr;
  endtask
  // Strobes stay low until ready is seen high, then data is taken
  task automatic cpu_finish();
    int n;
    n = 0;
    @(negedge mclk);
    while (localCpuReady !== 1'b1 && n < 2000) begin
      @(negedge mclk);
      n++;
    end
    cmp_bit(localCpuReady, 1'b1);
    if (localAddr[15]) begin
      cmp_bit(hostWait, 1'b1);
      cmp_bit(hostWr_n, localMemWrite_n);
      cmp_bit(dataOe, !localMemWrite_n);
      cmp_bit(prioOut_n, 1'b0);
    end
    @(negedge mclk);
    q = localReadData;
    @(posedge mclk);
    #1;
    localMemRead_n = 1'b1;
    localMemWrite_n = 1'b1;
    localAddr = 16'h0000;
  endtask
  task automatic t_reset();
    cmp_bit(holdOe, 1'b0);
    cmp_bit(holdOut_n, 1'b0);
    cmp_bit(hostWr_n, 1'b1);
    cmp_bit(cmdPend_n, 1'b1);
    cmp_bit(prioOut_n, 1'b1);
    $display("t_reset done");
  endtask
  task automatic t_write();
    cpu_start(16'hB234, 1'b1, 8'h5C);
    cpu_finish();
    wait_oe(1'b0);
    cmp_val({1'b0, wrAddr}, 16'h3234);
    cmp_val({8'h00, wrData}, 16'h005C);
    cmp_bit(driveEn, 1'b0);
    cmp_bit(hostWait, 1'b0);
    $display("t_write done");
  endtask
  // Slow host ready; model answers low address byte xor A5
  task automatic t_read();
    rdyDelay = 4'h6;
    cpu_start(16'hFFFF, 1'b0, 8'h00);
    cpu_finish();
    cmp_val({8'h00, q}, 16'h005A);
    wait_oe(1'b0);
    rdyDelay = 4'h0;
    $display("t_read done");
  endtask
  task automatic t_cmd();
    h_wait(1);
    hostCmdWrite = 1'b1;
    hostCmdData = 8'h3C;
    h_wait(1);
    hostCmdWrite = 1'b0;
    h_wait(1);
    cmp_bit(cmdPend_n, 1'b0);
    wait_oe(1'b1);
    cpu_start(16'hC001, 1'b1, 8'h77);
    cpu_finish();
    h_wait(6);
    cmp_bit(holdOe, 1'b1);
    cmp_bit(driveEn, 1'b1);
    cmp_bit(hostWait, 1'b0);
    cmp_val({8'h00, wrData}, 16'h0077);
    cpu_start(16'h1800, 1'b0, 8'h00);
    cpu_finish();
    cmp_val({8'h00, q}, 16'h0001);
    cpu_start(16'h1400, 1'b0, 8'h00);
    cpu_finish();
    cmp_val({8'h00, q}, 16'h003C);
    wait_oe(1'b0);
    cmp_bit(cmdPend_n, 1'b1);
    $display("t_cmd done");
  endtask
  task automatic t_chain();
    h_wait(1);
    chainPriorityInDriven = 1'b1;
    cpu_start(16'h8010, 1'b0, 8'h00);
    h_wait(10);
    cmp_bit(holdOe, 1'b0);
    cmp_bit(prioOut_n, 1'b0);
    cmp_bit(localCpuReady, 1'b0);
    chainPriorityIn_n = 1'b1;
    otherHold_n = 1'b0;
    h_wait(10);
    cmp_bit(holdOe, 1'b0);
    otherHold_n = 1'b1;
    cpu_finish();
    cmp_val({8'h00, q}, 16'h00B5);
    wait_oe(1'b0);
    $display("t_chain done");
  endtask
  // Priority lost one edge after the start; the device retries later
  task automatic t_abort();
    ackDelay = 4'h6;
    cpu_start(16'h8020, 1'b1, 8'hE1);
    wait_oe(1'b1);
    cmp_bit(prioOut_n, 1'b0);
    chainPriorityIn_n = 1'b0;
    h_wait(2);
    cmp_bit(holdOe, 1'b0);
    h_wait(4);
    cmp_bit(holdOe, 1'b0);
    chainPriorityIn_n = 1'b1;
    ackDelay = 4'h1;
    cpu_finish();
    wait_oe(1'b0);
    cmp_val({8'h00, wrData}, 16'h00E1);
    $display("t_abort done");
  endtask
  task automatic close_out();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling far above the few hundred cycles the tests need
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      close_out();
    end
  end
  // Reset 8 cycles, then each scenario in turn
  initial begin
    repeat (8) @(posedge mclk);
    #1;
    arst_n = 1'b1;
    h_wait(4);
    t_reset();
    t_write();
    t_read();
    t_cmd();
    t_chain();
    t_abort();
    close_out();
  end
endmodule
